// ===== core/gcr_defs.svh
`ifndef GCR_DEFS_SVH
`define GCR_DEFS_SVH
// register offsets
`define GCR_OFS_SWRST 8'h02
`define GCR_OFS_LDSEL 8'h07
`define GCR_OFS_TYPA 8'h10
`define GCR_OFS_TYPB 8'h11
`define GCR_OFS_POLH 8'h13
`define GCR_OFS_POLL 8'h14
`define GCR_OFS_PINA 8'h1a
`define GCR_OFS_PINB 8'h1b
`define GCR_OFS_GOPT 8'h26
`define GCR_OFS_GOPT2 8'h27
// reset values
`define GCR_RST_SWRST 8'h00
`define GCR_RST_LDSEL 8'h00
`define GCR_RST_TYPA 8'hff
`define GCR_RST_TYPB 8'hff
`define GCR_RST_POLH 8'h00
`define GCR_RST_POLL 8'h00
`define GCR_RST_PINA 8'hf0
`define GCR_RST_PINB 8'h78
`define GCR_RST_GOPT 8'h00
`define GCR_RST_GOPT2 8'h00
`define GCR_RSV_HI 8'hff
`define GCR_RSV_LO 8'h00
// writable bit masks
`define GCR_WM_TYPA 8'h2f
`define GCR_WM_TYPB 8'hc2
`define GCR_WM_PINA 8'h0c
`define GCR_WM_PINB 8'h16
`define GCR_WM_GOPT 8'h73
`define GCR_WM_GOPT2 8'hff
// field positions
`define GCR_BIT_PORTSEL 6
`define GCR_BIT_GATE 4
`define GCR_BIT_IRRX 3
`define GCR_BIT_CONSUMER_INFRARED_RX_INPUT 4
`define GCR_LSB_PIN23 2
`define GCR_LSB_PIN22 1
`endif

// ===== core/gcr_pkg.sv
`default_nettype none
package gcr_pkg;
	typedef logic [7:0] gcr_byte_t;
	typedef enum logic [3:0] {
		gcr_fn_rsvd = 4'h0, gcr_fn_mouse_clock_line = 4'h1, gcr_fn_sbus_clk = 4'h2,
		gcr_fn_general_io_41 = 4'h3, gcr_fn_mouse_data_line = 4'h4, gcr_fn_sbus_data = 4'h5,
		gcr_fn_beep = 4'h6, gcr_fn_general_io_42 = 4'h7, gcr_fn_consumer_infrared_rx_input = 4'h8,
		gcr_fn_general_io_24 = 4'h9, gcr_fn_infrared_rx_input = 4'ha
	} gcr_pin_fn_t;
	// keeps reserved bits, takes writable ones
	function automatic gcr_byte_t gcr_merge(gcr_byte_t old_v, gcr_byte_t new_v, gcr_byte_t mask);
		return (old_v & ~mask) | (new_v & mask);
	endfunction
endpackage
`default_nettype wire

// ===== core/gcr_if.sv
`default_nettype none
interface gcr_irq_if;
	logic [7:0] type_a;
	logic [7:0] type_b;
	logic [7:0] pol_hi;
	logic [7:0] pol_lo;
	modport ctrl (output type_a, type_b, pol_hi, pol_lo);
	modport shaper (input type_a, type_b, pol_hi, pol_lo);
endinterface

interface gcr_pin_if;
	logic [7:0] pin_a;
	logic [7:0] pin_b;
	logic irrx_sel;
	modport ctrl (output pin_a, pin_b, irrx_sel);
	modport mux (input pin_a, pin_b, irrx_sel);
endinterface
`default_nettype wire

// ===== core/gcr_irq_shaper.sv
`include "gcr_defs.svh"
`default_nettype none
module gcr_irq_shaper (
	input wire logic clock_i,
	input wire logic rstn_i,
	gcr_irq_if.shaper cfg,
	// sources: hm, watchdog_timeout, smi, uart, kbc, mouse, cir, cir wake
	input wire logic [7:0] src_i,
	input wire logic [31:0] chan_i,
	output logic [15:0] irq_line_o
);
	logic [7:0] src_prev_q;
	logic [7:0] type_v;
	logic [7:0] act_v;
	logic [15:0] pol_v;
	logic [15:0] line_d;
	logic [15:0] line_q;

	assign type_v = {cfg.type_b[7], cfg.type_b[6], cfg.type_b[1], cfg.type_a[5], cfg.type_a[3:0]};
	assign act_v = type_v & src_i | ~type_v & src_i & ~src_prev_q;
	assign pol_v = {cfg.pol_hi, cfg.pol_lo};

	always_comb begin
		line_d = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			line_d[chan_i[i*4 +: 4]] = line_d[chan_i[i*4 +: 4]] | act_v[i];
		end
		line_d = line_d ^ pol_v;
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			src_prev_q <= 8'h00;
			line_q <= 16'h0000;
		end else begin
			src_prev_q <= src_i;
			line_q <= line_d;
		end
	end
	assign irq_line_o = line_q;

	a_level_holds: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(type_v[7] && src_i[7] && src_prev_q[7])
		|=> irq_line_o[$past(chan_i[31:28])] != $past(pol_v[chan_i[31:28]]))
		else $error("level interrupt dropped");
	a_edge_single: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(!type_v[0] && src_i == 8'h01 && src_prev_q == 8'h01)
		|=> irq_line_o == $past(pol_v)) else $error("edge interrupt repeated");
	a_pol_idle: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(src_i == 8'h00 && src_prev_q == 8'h00 && $stable(pol_v)) |=> irq_line_o == $past(pol_v))
		else $error("idle polarity wrong");
endmodule
`default_nettype wire

// ===== core/gcr_pin_mux.sv
`include "gcr_defs.svh"
`default_nettype none
module gcr_pin_mux (
	input wire logic clock_i,
	input wire logic rstn_i,
	gcr_pin_if.mux cfg,
	input wire logic test_mode_i,
	output gcr_pkg::gcr_pin_fn_t pin23_fn_o,
	output gcr_pkg::gcr_pin_fn_t pin22_fn_o,
	output gcr_pkg::gcr_pin_fn_t pin46_fn_o
);
	logic [1:0] f23;
	logic [1:0] f22;
	gcr_pkg::gcr_pin_fn_t p23_d;
	gcr_pkg::gcr_pin_fn_t p22_d;
	gcr_pkg::gcr_pin_fn_t p46_d;

	assign f23 = cfg.pin_a[`GCR_LSB_PIN23 +: 2];
	assign f22 = cfg.pin_b[`GCR_LSB_PIN22 +: 2];
	assign p23_d = test_mode_i ? gcr_pkg::gcr_fn_rsvd :
		f23 == 2'h1 ? gcr_pkg::gcr_fn_sbus_clk :
		f23 == 2'h2 ? gcr_pkg::gcr_fn_general_io_41 : gcr_pkg::gcr_fn_mouse_clock_line;
	assign p22_d = test_mode_i ? gcr_pkg::gcr_fn_rsvd :
		f22 == 2'h0 ? gcr_pkg::gcr_fn_mouse_data_line :
		f22 == 2'h1 ? gcr_pkg::gcr_fn_sbus_data :
		f22 == 2'h2 ? gcr_pkg::gcr_fn_beep : gcr_pkg::gcr_fn_general_io_42;
	assign p46_d = cfg.pin_b[`GCR_BIT_CONSUMER_INFRARED_RX_INPUT] ? gcr_pkg::gcr_fn_consumer_infrared_rx_input :
		cfg.irrx_sel ? gcr_pkg::gcr_fn_infrared_rx_input : gcr_pkg::gcr_fn_general_io_24;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin23_fn_o <= gcr_pkg::gcr_fn_rsvd;
			pin22_fn_o <= gcr_pkg::gcr_fn_rsvd;
			pin46_fn_o <= gcr_pkg::gcr_fn_rsvd;
		end else begin
			pin23_fn_o <= p23_d;
			pin22_fn_o <= p22_d;
			pin46_fn_o <= p46_d;
		end
	end

	a_pin23_route: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(!test_mode_i && f23 == 2'h2) |=> pin23_fn_o == gcr_pkg::gcr_fn_general_io_41)
		else $error("pin23 route wrong");
	a_pin22_route: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(!test_mode_i && f22 == 2'h3) |=> pin22_fn_o == gcr_pkg::gcr_fn_general_io_42)
		else $error("pin22 route wrong");
	a_pin46_route: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(!cfg.pin_b[`GCR_BIT_CONSUMER_INFRARED_RX_INPUT] && cfg.irrx_sel) |=> pin46_fn_o == gcr_pkg::gcr_fn_infrared_rx_input)
		else $error("pin46 route wrong");
	a_test_rsvd: assert property (@(posedge clock_i) disable iff (!rstn_i)
		test_mode_i |=> pin23_fn_o == gcr_pkg::gcr_fn_rsvd && pin22_fn_o == gcr_pkg::gcr_fn_rsvd)
		else $error("test strap ignored");
endmodule
`default_nettype wire

// ===== core/gcr_regs.sv
`include "gcr_defs.svh"
`default_nettype none
// Operation
// - strap-derived bits read back the level sampled on their strap pin
// - firmware may overwrite strap-derived bits afterwards; reads return written value
// - 07h is a read/write logical device number, reset to zero
// - 10h bit 5 picks edge or level for the first serial port
// - 10h bits 3..0 pick edge or level for keyboard, mouse, infrared, wake
// - 11h bits 7, 6, 1 pick edge or level for monitor, watchdog, management
// - 13h sets polarity of channels 15..8, one means active low
// - 14h sets polarity of channels 7..0, one means active low
// - 1Ah bits 3..2 route pin 23 unless test strap high
// - 1Bh bits 2..1 route pin 22 unless test strap high
// - pin 46 is infrared input per 1Bh bit 4 and 27h bit 3
// - 07h, 10h, 11h, 13h, 14h return to defaults on bus reset
// - 1Ah and 1Bh reset only by resume reset, to F0h and 78h
// - 02h is write-only, zero default, cleared by bus reset
module gcr_regs (
	// clock and resets
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic resume_rstn_i,
	// straps
	input wire logic config_port_select_strap_i,
	input wire logic test_mode_strap_i,
	// configuration data port, index already latched
	input wire logic [7:0] cfg_index_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	// configuration outputs
	output logic [7:0] logical_device_o,
	output logic [7:0] soft_reset_slot_o,
	output logic config_port_select_o,
	output logic irq_access_gate_o,
	// interrupt sources and lines
	input wire logic [7:0] func_irq_i,
	input wire logic [31:0] func_chan_i,
	output logic [15:0] irq_line_o,
	// shared pin functions
	output gcr_pkg::gcr_pin_fn_t pin23_fn_o,
	output gcr_pkg::gcr_pin_fn_t pin22_fn_o,
	output gcr_pkg::gcr_pin_fn_t pin46_fn_o
);
	gcr_irq_if irq_bus ();
	gcr_pin_if pin_bus ();

	gcr_pkg::gcr_byte_t swrst_q;
	gcr_pkg::gcr_byte_t ldsel_q;
	gcr_pkg::gcr_byte_t typa_q;
	gcr_pkg::gcr_byte_t typb_q;
	gcr_pkg::gcr_byte_t polh_q;
	gcr_pkg::gcr_byte_t poll_q;
	gcr_pkg::gcr_byte_t gopt_q;
	gcr_pkg::gcr_byte_t gopt_d;
	gcr_pkg::gcr_byte_t pina_q;
	gcr_pkg::gcr_byte_t pinb_q;
	gcr_pkg::gcr_byte_t gopt2_q;
	gcr_pkg::gcr_byte_t rdata_d;
	gcr_pkg::gcr_byte_t rdata_q;
	logic strap_done_q;
	logic test_done_q;
	logic test_mode_q;

	// address decode
	logic wr_swrst;
	logic wr_ldsel;
	logic wr_typa;
	logic wr_typb;
	logic wr_polh;
	logic wr_poll;
	logic wr_gopt;
	logic wr_pina;
	logic wr_pinb;
	logic wr_gopt2;
	logic rsv_hi;
	logic rsv_lo;

	assign wr_swrst = cfg_wr_i && cfg_index_i == `GCR_OFS_SWRST;
	assign wr_ldsel = cfg_wr_i && cfg_index_i == `GCR_OFS_LDSEL;
	assign wr_typa = cfg_wr_i && cfg_index_i == `GCR_OFS_TYPA;
	assign wr_typb = cfg_wr_i && cfg_index_i == `GCR_OFS_TYPB;
	assign wr_polh = cfg_wr_i && cfg_index_i == `GCR_OFS_POLH;
	assign wr_poll = cfg_wr_i && cfg_index_i == `GCR_OFS_POLL;
	assign wr_gopt = cfg_wr_i && cfg_index_i == `GCR_OFS_GOPT;
	assign wr_pina = cfg_wr_i && cfg_index_i == `GCR_OFS_PINA;
	assign wr_pinb = cfg_wr_i && cfg_index_i == `GCR_OFS_PINB;
	assign wr_gopt2 = cfg_wr_i && cfg_index_i == `GCR_OFS_GOPT2;

	// reserved global registers keep their defaults
	assign rsv_hi = cfg_index_i inside {8'h16, 8'h17, 8'h18, 8'h19, 8'h1e, 8'h1f};
	assign rsv_lo = cfg_index_i inside {8'h1d, 8'h23, 8'h2e};

	// main well registers
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			swrst_q <= `GCR_RST_SWRST;
			ldsel_q <= `GCR_RST_LDSEL;
			typa_q <= `GCR_RST_TYPA;
			typb_q <= `GCR_RST_TYPB;
			polh_q <= `GCR_RST_POLH;
			poll_q <= `GCR_RST_POLL;
		end else begin
			if (wr_swrst) begin
				swrst_q <= cfg_wdata_i;
			end
			if (wr_ldsel) begin
				ldsel_q <= cfg_wdata_i;
			end
			if (wr_typa) begin
				typa_q <= gcr_pkg::gcr_merge(typa_q, cfg_wdata_i, `GCR_WM_TYPA);
			end
			if (wr_typb) begin
				typb_q <= gcr_pkg::gcr_merge(typb_q, cfg_wdata_i, `GCR_WM_TYPB);
			end
			if (wr_polh) begin
				polh_q <= cfg_wdata_i;
			end
			if (wr_poll) begin
				poll_q <= cfg_wdata_i;
			end
		end
	end

	// strap-derived option bit, loaded once after release
	always_comb begin
		gopt_d = gopt_q;
		if (!strap_done_q) begin
			gopt_d[`GCR_BIT_PORTSEL] = config_port_select_strap_i;
		end
		if (wr_gopt) begin
			gopt_d = gcr_pkg::gcr_merge(gopt_q, cfg_wdata_i, `GCR_WM_GOPT);
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gopt_q <= `GCR_RST_GOPT;
			strap_done_q <= 1'b0;
		end else begin
			gopt_q <= gopt_d;
			strap_done_q <= 1'b1;
		end
	end

	// standby well registers
	always_ff @(posedge clock_i or negedge resume_rstn_i) begin
		if (!resume_rstn_i) begin
			pina_q <= `GCR_RST_PINA;
			pinb_q <= `GCR_RST_PINB;
			gopt2_q <= `GCR_RST_GOPT2;
		end else begin
			if (wr_pina) begin
				pina_q <= gcr_pkg::gcr_merge(pina_q, cfg_wdata_i, `GCR_WM_PINA);
			end
			if (wr_pinb) begin
				pinb_q <= gcr_pkg::gcr_merge(pinb_q, cfg_wdata_i, `GCR_WM_PINB);
			end
			if (wr_gopt2) begin
				gopt2_q <= gcr_pkg::gcr_merge(gopt2_q, cfg_wdata_i, `GCR_WM_GOPT2);
			end
		end
	end

	// test strap caught after resume release
	always_ff @(posedge clock_i or negedge resume_rstn_i) begin
		if (!resume_rstn_i) begin
			test_done_q <= 1'b0;
			test_mode_q <= 1'b0;
		end else begin
			test_done_q <= 1'b1;
			if (!test_done_q) begin
				test_mode_q <= test_mode_strap_i;
			end
		end
	end

	// read mux, write-only slot reads zero
	always_comb begin
		unique case (1'b1)
			cfg_index_i == `GCR_OFS_LDSEL: rdata_d = ldsel_q;
			cfg_index_i == `GCR_OFS_TYPA: rdata_d = typa_q;
			cfg_index_i == `GCR_OFS_TYPB: rdata_d = typb_q;
			cfg_index_i == `GCR_OFS_POLH: rdata_d = polh_q;
			cfg_index_i == `GCR_OFS_POLL: rdata_d = poll_q;
			cfg_index_i == `GCR_OFS_PINA: rdata_d = pina_q;
			cfg_index_i == `GCR_OFS_PINB: rdata_d = pinb_q;
			cfg_index_i == `GCR_OFS_GOPT: rdata_d = gopt_q;
			cfg_index_i == `GCR_OFS_GOPT2: rdata_d = gopt2_q;
			rsv_hi: rdata_d = `GCR_RSV_HI;
			default: rdata_d = `GCR_RSV_LO;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= 8'h00;
		end else if (cfg_rd_i) begin
			rdata_q <= rdata_d;
		end
	end

	// sub-block connections
	assign irq_bus.type_a = typa_q;
	assign irq_bus.type_b = typb_q;
	assign irq_bus.pol_hi = polh_q;
	assign irq_bus.pol_lo = poll_q;
	assign pin_bus.pin_a = pina_q;
	assign pin_bus.pin_b = pinb_q;
	assign pin_bus.irrx_sel = gopt2_q[`GCR_BIT_IRRX];

	gcr_irq_shaper u_shaper (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.cfg(irq_bus.shaper),
		.src_i(func_irq_i),
		.chan_i(func_chan_i),
		.irq_line_o(irq_line_o)
	);

	gcr_pin_mux u_pin_mux (
		.clock_i(clock_i),
		.rstn_i(resume_rstn_i),
		.cfg(pin_bus.mux),
		.test_mode_i(test_mode_q),
		.pin23_fn_o(pin23_fn_o),
		.pin22_fn_o(pin22_fn_o),
		.pin46_fn_o(pin46_fn_o)
	);

	// outputs
	assign cfg_rdata_o = rdata_q;
	assign logical_device_o = ldsel_q;
	assign soft_reset_slot_o = swrst_q;
	assign config_port_select_o = gopt_q[`GCR_BIT_PORTSEL];
	assign irq_access_gate_o = gopt_q[`GCR_BIT_GATE];

	// checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	a_strap_sampled: assert property (
		(!strap_done_q && !wr_gopt) |=> gopt_q[`GCR_BIT_PORTSEL] == $past(config_port_select_strap_i))
		else $error("strap bit not sampled");
	a_strap_override: assert property (
		(strap_done_q && wr_gopt) |=> gopt_q[`GCR_BIT_PORTSEL] == $past(cfg_wdata_i[`GCR_BIT_PORTSEL]))
		else $error("strap bit not writable");
	a_strap_hold: assert property (
		(strap_done_q && !wr_gopt) |=> $stable(gopt_q))
		else $error("option register changed unwritten");
	a_ldsel_readback: assert property (
		(cfg_rd_i && cfg_index_i == `GCR_OFS_LDSEL && !cfg_wr_i)
		|=> cfg_rdata_o == $past(ldsel_q) && cfg_rdata_o == logical_device_o)
		else $error("device number readback wrong");
	a_type_rsvd: assert property (
		(wr_typa || wr_typb) |=> (typa_q & ~`GCR_WM_TYPA) == (`GCR_RST_TYPA & ~`GCR_WM_TYPA)
		&& (typb_q & ~`GCR_WM_TYPB) == (`GCR_RST_TYPB & ~`GCR_WM_TYPB))
		else $error("reserved type bits moved");
	a_type_write: assert property (
		wr_typa |=> typa_q[5] == $past(cfg_wdata_i[5]) && typa_q[3:0] == $past(cfg_wdata_i[3:0]))
		else $error("type select not stored");
	a_pol_write: assert property (
		wr_poll |=> poll_q == $past(cfg_wdata_i) && irq_bus.pol_lo == poll_q)
		else $error("polarity not stored");
	a_bus_reset: assert property (
		$rose(strap_done_q) |-> ldsel_q == `GCR_RST_LDSEL && typa_q == `GCR_RST_TYPA
		&& typb_q == `GCR_RST_TYPB && polh_q == `GCR_RST_POLH && poll_q == `GCR_RST_POLL)
		else $error("main well defaults wrong");
	a_resume_reset: assert property (@(posedge clock_i) disable iff (!resume_rstn_i)
		$rose(test_done_q) |-> pina_q == `GCR_RST_PINA && pinb_q == `GCR_RST_PINB)
		else $error("standby defaults wrong");
	a_wo_reads_zero: assert property (
		(cfg_rd_i && cfg_index_i == `GCR_OFS_SWRST) |=> cfg_rdata_o == 8'h00)
		else $error("write-only slot readable");
	a_pin_rsvd: assert property (
		wr_pina |=> pina_q[7:4] == 4'hf && pina_q[1:0] == 2'h0)
		else $error("reserved pin bits moved");

	c_strap_write: cover property (strap_done_q && wr_gopt);
	c_ldsel_read: cover property (wr_ldsel ##3 (cfg_rd_i && cfg_index_i == `GCR_OFS_LDSEL));
	c_level_irq: cover property (func_irq_i != 8'h00 && typa_q != 8'h00);
	c_pin_test: cover property (test_mode_q && wr_pinb);
endmodule
`default_nettype wire

// ===== tb/gcr_host_model.sv
`default_nettype none
module gcr_host_model #(
	parameter int IDLE = 1
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// register port
	output logic [7:0] cfg_index_o,
	output logic cfg_wr_o,
	output logic cfg_rd_o,
	output logic [7:0] cfg_wdata_o,
	input wire logic [7:0] cfg_rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic gate_ok;
	initial begin
		cfg_index_o = 8'h00;
		cfg_wr_o = 1'b0;
		cfg_rd_o = 1'b0;
		cfg_wdata_o = 8'h00;
		gate_ok = 1'b0;
	end
	always @(negedge rstn_i) begin
		gate_ok = 1'b0;
	end
	function automatic logic gated(input logic [7:0] idx);
		return idx inside {8'h10, 8'h11, 8'h13, 8'h14};
	endfunction
	function automatic logic rsvd(input logic [7:0] idx);
		return idx inside {8'h02, [8'h16:8'h19], [8'h1d:8'h1f], 8'h23, 8'h2e};
	endfunction
	// one cycle, config mode taken as entered by two key writes
	task automatic cyc(input logic w, input logic [7:0] idx, input logic [7:0] val, output logic [7:0] rv);
		repeat (IDLE) @(negedge clock_i);
		cfg_index_o = idx;
		cfg_wdata_o = val;
		cfg_wr_o = w;
		cfg_rd_o = !w;
		@(negedge clock_i);
		cfg_wr_o = 1'b0;
		cfg_rd_o = 1'b0;
		cfg_wdata_o = ~val;
		@(negedge clock_i);
		rv = cfg_rdata_i;
		if (w && idx == 8'h26) begin
			gate_ok = val[4];
		end
	endtask
	// gate bit set before type and polarity access
	task automatic open_gate();
		logic [7:0] v;
		cyc(1'b0, 8'h26, 8'h00, v);
		cyc(1'b1, 8'h26, v | 8'h10, v);
	endtask
	task automatic rd_reg(input logic [7:0] idx, output logic [7:0] rv);
		if (gated(idx) && !gate_ok) begin
			open_gate();
		end
		cyc(1'b0, idx, 8'h00, rv);
	endtask
	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
		logic [7:0] rv;
		if (rsvd(idx)) begin
			return;
		end
		if (gated(idx) && !gate_ok) begin
			open_gate();
		end
		cyc(1'b1, idx, val, rv);
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic resume_rstn_i = 1'b0;
	logic config_port_select_strap_i = 1'b1;
	logic test_mode_strap_i = 1'b0;
	logic [7:0] cfg_index_i;
	logic cfg_wr_i;
	logic cfg_rd_i;
	logic [7:0] cfg_wdata_i;
	logic [7:0] cfg_rdata_o;
	logic [7:0] logical_device_o;
	logic [7:0] soft_reset_slot_o;
	logic config_port_select_o;
	logic irq_access_gate_o;
	logic [7:0] func_irq_i = 8'h00;
	logic [31:0] func_chan_i = 32'heca86420;
	logic [15:0] irq_line_o;
	gcr_pkg::gcr_pin_fn_t pin23_fn_o;
	gcr_pkg::gcr_pin_fn_t pin22_fn_o;
	gcr_pkg::gcr_pin_fn_t pin46_fn_o;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #4 clock_i = ~clock_i;
	gcr_regs i_gcr_regs (
		.clock_i, .rstn_i, .resume_rstn_i, .config_port_select_strap_i, .test_mode_strap_i,
		.cfg_index_i, .cfg_wr_i, .cfg_rd_i, .cfg_wdata_i, .cfg_rdata_o, .logical_device_o,
		.soft_reset_slot_o, .config_port_select_o, .irq_access_gate_o, .func_irq_i, .func_chan_i,
		.irq_line_o, .pin23_fn_o, .pin22_fn_o, .pin46_fn_o
	);
	gcr_host_model #(.IDLE(1)) i_gcr_host_model (
		.clock_i, .rstn_i, .cfg_index_o(cfg_index_i), .cfg_wr_o(cfg_wr_i),
		.cfg_rd_o(cfg_rd_i), .cfg_wdata_o(cfg_wdata_i), .cfg_rdata_i(cfg_rdata_o)
	);
	task automatic conclude();
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		i_gcr_host_model.wr_reg(idx, val);
	endtask
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		i_gcr_host_model.rd_reg(idx, v);
		check({8'h00, v}, {8'h00, exp});
	endtask
	task automatic pulse_reset(input logic bus);
		if (bus) begin
			rstn_i = 1'b0;
		end else begin
			resume_rstn_i = 1'b0;
		end
		repeat (2) @(negedge clock_i);
		rstn_i = 1'b1;
		resume_rstn_i = 1'b1;
		repeat (2) @(negedge clock_i);
	endtask
	task automatic t_defaults();
		rd_chk(8'h26, 8'h40);
		check({15'h0, config_port_select_o}, 16'h0001);
		rd_chk(8'h07, 8'h00);
		rd_chk(8'h10, 8'hff);
		rd_chk(8'h11, 8'hff);
		rd_chk(8'h13, 8'h00);
		rd_chk(8'h14, 8'h00);
		rd_chk(8'h1a, 8'hf0);
		rd_chk(8'h1b, 8'h78);
		rd_chk(8'h02, 8'h00);
		check({8'h00, soft_reset_slot_o}, 16'h0000);
		check({12'h0, pin23_fn_o}, {12'h0, gcr_pkg::gcr_fn_mouse_clock_line});
		check({12'h0, pin22_fn_o}, {12'h0, gcr_pkg::gcr_fn_mouse_data_line});
		check({12'h0, pin46_fn_o}, {12'h0, gcr_pkg::gcr_fn_consumer_infrared_rx_input});
	endtask
	task automatic t_masks();
		logic [7:0] idx [8] = '{8'h07, 8'h10, 8'h10, 8'h11, 8'h13, 8'h14, 8'h1a, 8'h1b};
		logic [7:0] wv [8] = '{8'h5a, 8'h00, 8'h2f, 8'h00, 8'ha5, 8'h3c, 8'h03, 8'he9};
		logic [7:0] ev [8] = '{8'h5a, 8'hd0, 8'hff, 8'h3d, 8'ha5, 8'h3c, 8'hf0, 8'h68};
		for (int i = 0; i < 8; i++) begin
			wr(idx[i], wv[i]);
			rd_chk(idx[i], ev[i]);
		end
		check({8'h00, logical_device_o}, 16'h005a);
		wr(8'h26, 8'h10);
		rd_chk(8'h26, 8'h10);
		check({15'h0, config_port_select_o}, 16'h0000);
		check({15'h0, irq_access_gate_o}, 16'h0001);
	endtask
	task automatic t_pins();
		gcr_pkg::gcr_pin_fn_t e23 [4] = '{gcr_pkg::gcr_fn_mouse_clock_line, gcr_pkg::gcr_fn_sbus_clk,
			gcr_pkg::gcr_fn_general_io_41, gcr_pkg::gcr_fn_mouse_clock_line};
		gcr_pkg::gcr_pin_fn_t e22 [4] = '{gcr_pkg::gcr_fn_mouse_data_line, gcr_pkg::gcr_fn_sbus_data,
			gcr_pkg::gcr_fn_beep, gcr_pkg::gcr_fn_general_io_42};
		gcr_pkg::gcr_pin_fn_t e46 [4] = '{gcr_pkg::gcr_fn_general_io_24, gcr_pkg::gcr_fn_infrared_rx_input,
			gcr_pkg::gcr_fn_consumer_infrared_rx_input, gcr_pkg::gcr_fn_consumer_infrared_rx_input};
		for (int c = 0; c < 4; c++) begin
			wr(8'h1a, {4'hf, c[1:0], 2'b00});
			wr(8'h1b, {5'b01111, c[1:0], 1'b0});
			check({12'h0, pin23_fn_o}, {12'h0, e23[c]});
			check({12'h0, pin22_fn_o}, {12'h0, e22[c]});
			wr(8'h27, {4'h0, c[0], 3'b000});
			wr(8'h1b, {3'b011, c[1], 4'h8});
			check({12'h0, pin46_fn_o}, {12'h0, e46[c]});
		end
	endtask
	task automatic t_irq(input logic lvl);
		logic [15:0] idle;
		logic [15:0] act;
		idle = lvl ? 16'hffff : 16'h0000;
		wr(8'h10, {8{lvl}});
		wr(8'h11, {8{lvl}});
		wr(8'h13, {8{lvl}});
		wr(8'h14, {8{lvl}});
		for (int s = 0; s < 8; s++) begin
			act = idle ^ (16'h0001 << (2 * s));
			func_irq_i = 8'h01 << s;
			@(negedge clock_i);
			check(irq_line_o, act);
			@(negedge clock_i);
			check(irq_line_o, lvl ? act : idle);
			@(negedge clock_i);
			check(irq_line_o, lvl ? act : idle);
			func_irq_i = 8'h00;
			repeat (2) @(negedge clock_i);
			check(irq_line_o, idle);
		end
	endtask
	task automatic t_wells();
		wr(8'h1a, 8'hfc);
		wr(8'h10, 8'h00);
		config_port_select_strap_i = 1'b0;
		pulse_reset(1'b1);
		rd_chk(8'h26, 8'h00);
		rd_chk(8'h07, 8'h00);
		rd_chk(8'h10, 8'hff);
		rd_chk(8'h1a, 8'hfc);
		test_mode_strap_i = 1'b1;
		pulse_reset(1'b0);
		rd_chk(8'h1a, 8'hf0);
		rd_chk(8'h1b, 8'h78);
		check({12'h0, pin23_fn_o}, {12'h0, gcr_pkg::gcr_fn_rsvd});
		check({12'h0, pin22_fn_o}, {12'h0, gcr_pkg::gcr_fn_rsvd});
	endtask
	initial begin
		repeat (10) @(negedge clock_i);
		rstn_i = 1'b1;
		resume_rstn_i = 1'b1;
		repeat (2) @(negedge clock_i);
		t_defaults();
		t_masks();
		t_pins();
		t_irq(1'b0);
		t_irq(1'b1);
		t_wells();
		conclude();
	end
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, cycles, 0);
			conclude();
		end
	end
endmodule
`default_nettype wire
